// [pkg/cg_params.svh]
`ifndef CG_PARAMS_SVH
`define CG_PARAMS_SVH
// register indices, byte address is index * 4 (printed offsets not all multiples of four)
`define CG_IDX_COMP_HI 8'h0d
`define CG_IDX_COMP_LO 8'h0e
`define CG_IDX_ENER_HI 8'h0f
`define CG_IDX_ENER_LO 8'h10
`define CG_IDX_RESET 8'h39
`define CG_IDX_NOM_HI 8'h03
`define CG_IDX_NOM_LO 8'h17
`define CG_IDX_MFR 8'h05
`define CG_IDX_CPI 8'h09
`define CG_IDX_VTS 8'h0c
`define CG_IDX_FLAGS 8'h3a
`define CG_IDX_CTRL 8'h3b
// reset values
`define CG_RST_TRIGGER 8'h80
`define CG_RST_IDLE 8'h00
`define CG_VTS_RESET 8'ha2
// final threshold offset: 50 mV at 2.4 V / 256 per lsb, rounded
`define CG_FINAL_EMPTY_WARNING_DELTA 8'h05
// flag bit positions in the flags register
`define CG_FLG_CI 0
`define CG_FLG_BRP 1
`define CG_FLG_VDQ 2
`define CG_FLG_FIRST_EMPTY_WARNING 3
`define CG_FLG_FINAL_EMPTY_WARNING 4
// timing
`define CG_CLK_HZ 25000000
`define CG_DISPLAY_ENABLE_PIN_MS 4000
`define CG_MOD_HZ 100
`define CG_BLINK_HZ 4
`define CG_BANK_PCT 30
`define CG_SEG_PCT 20
`endif

// [pkg/cg_pkg.sv]
`default_nettype none
package cg_pkg;
  typedef enum logic [2:0] {
    CG_DSP_OFF = 3'b001,
    CG_DSP_TIMED = 3'b010,
    CG_DSP_CHARGE = 3'b100
  } cg_dsp_t;
  typedef logic [15:0] cg_word_t;
endpackage : cg_pkg
`default_nettype wire

// [hw/cg_led_mux.sv]
`default_nettype none
`include "cg_params.svh"
module cg_led_mux #(
  parameter int unsigned MOD_CYCLES = `CG_CLK_HZ / `CG_MOD_HZ,
  parameter int unsigned BLINK_CYCLES = `CG_CLK_HZ / (2 * `CG_BLINK_HZ)
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // display request
  input wire logic show_i,
  input wire logic [4:0] lit_i,
  input wire logic first_empty_warning_i,
  input wire logic final_empty_warning_i,
  // pins
  output logic [4:0] seg_o,
  output logic com_o
);
  import cg_pkg::*;
  localparam int unsigned BANK_CYCLES = (MOD_CYCLES * `CG_BANK_PCT) / 100;
  localparam int unsigned HALF = MOD_CYCLES / 2;
  logic [31:0] mod_cnt_r;
  logic [31:0] blink_cnt_r;
  logic blink_r;
  logic [4:0] seg_r;
  logic com_r;
  wire bank_a_on = mod_cnt_r < BANK_CYCLES;
  wire bank_b_on = (mod_cnt_r >= HALF) && (mod_cnt_r < HALF + BANK_CYCLES);
  // odd segments in bank a, even in bank b
  wire [4:0] bank_mask = bank_a_on ? 5'h15 : (bank_b_on ? 5'h0a : 5'h00);
  // blink gates segment one on top of the mux, never replaces it
  wire [4:0] blink_mask = (first_empty_warning_i && blink_r) ? 5'h1e : 5'h1f;
  wire [4:0] seg_nxt = (show_i && !final_empty_warning_i) ? (lit_i & bank_mask & blink_mask) : 5'h00;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mod_cnt_r <= 32'h0;
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b0;
      seg_r <= 5'h00;
      com_r <= 1'b0;
    end else begin
      mod_cnt_r <= (mod_cnt_r >= MOD_CYCLES - 1) ? 32'h0 : mod_cnt_r + 32'h1;
      if (blink_cnt_r >= BLINK_CYCLES - 1) begin
        blink_cnt_r <= 32'h0;
        blink_r <= !blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 32'h1;
      end
      seg_r <= seg_nxt;
      com_r <= |seg_nxt;
    end
  end
  assign seg_o = seg_r;
  assign com_o = com_r;
endmodule : cg_led_mux
`default_nettype wire

// [hw/cg_gauge_display.sv]
// Chosen here: the Wishbone register port.
`default_nettype none
`include "cg_params.svh"
module cg_gauge_display #(
  parameter int unsigned DISPLAY_ENABLE_PIN_CYCLES = (`CG_CLK_HZ / 1000) * `CG_DISPLAY_ENABLE_PIN_MS,
  parameter logic [15:0] PROG_FULL = 16'h1000,
  parameter logic [7:0] RATE_SHIFT = 8'h00
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // gauge inputs from the measurement core
  input wire logic [15:0] nominal_charge_count_i,
  input wire logic [7:0] temp_derate_i,
  input wire logic [7:0] cell_voltage_input_i,
  input wire logic valid_charge_i,
  input wire logic fifth_program_input_i,
  // display pins: enable pin as pulled-high and pulled-low sense lines
  input wire logic display_enable_high_i,
  input wire logic display_enable_low_i,
  output logic [4:0] segment_outputs_o,
  output logic led_common_o,
  // gauge reset and status toward the core
  output logic gauge_reset_o,
  output logic self_discharge_en_o,
  output logic [15:0] measured_full_reference_o
);
  import cg_pkg::*;
  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] dh_sync_r;
  logic [1:0] dl_sync_r;
  logic [1:0] vc_sync_r;
  logic [1:0] p5_sync_r;
  wire display_enable_pin_high = dh_sync_r[1];
  wire display_enable_pin_low = dl_sync_r[1];
  wire chg_valid = vc_sync_r[1];
  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] mfr_r;
  logic [15:0] nom_r;
  logic [7:0] cpi_r;
  logic [7:0] vts_r;
  logic [7:0] rst_reg_r;
  logic ci_r;
  logic brp_r;
  logic vdq_r;
  logic ack_r;
  logic err_r;
  logic [31:0] dat_r;
  logic [31:0] tmr_r;
  logic sd_dis_r;
  cg_dsp_t dsp_r;
  cg_dsp_t dsp_nxt;
  //////////////////////////////////////////////////////////////////////////////
  // compensation: only the copy is derated; nominal and reference untouched
  wire [23:0] comp_prod = nom_r * {8'h00, temp_derate_i};
  wire [15:0] comp_rt = comp_prod[23:8] >> RATE_SHIFT[3:0];
  wire [15:0] comp_val = comp_rt;
  // energy: voltage times compensated charge, upper bits kept
  wire [23:0] ener_prod = comp_val * {8'h00, cell_voltage_input_i};
  wire [15:0] ener_val = ener_prod[23:8];
  //////////////////////////////////////////////////////////////////////////////
  // thresholds
  wire first_empty_warning = cell_voltage_input_i < vts_r;
  wire [7:0] final_empty_warning_thr = (vts_r > `CG_FINAL_EMPTY_WARNING_DELTA) ? vts_r - `CG_FINAL_EMPTY_WARNING_DELTA : 8'h00;
  wire final_empty_warning = cell_voltage_input_i < final_empty_warning_thr;
  //////////////////////////////////////////////////////////////////////////////
  // relative display: segment k lit when charge exceeds k*20% of reference
  function automatic logic [4:0] cg_bar(input logic [15:0] chg, input logic [15:0] full);
    logic [4:0] b;
    // 24 bits: a full 16-bit charge times 100 must not wrap
    logic [23:0] lhs;
    logic [23:0] thr;
    b = 5'h00;
    lhs = {8'h00, chg} * 24'd100;
    for (int k = 0; k < 5; k++) begin
      thr = {8'h00, full} * 24'(`CG_SEG_PCT * k);
      b[k] = (chg != 16'h0) && (lhs > thr);
    end
    return b;
  endfunction : cg_bar
  wire [4:0] lit = cg_bar(comp_val, mfr_r);
  //////////////////////////////////////////////////////////////////////////////
  // wishbone decode
  wire req = cyc_i && stb_i && !ack_r && !err_r;
  wire [7:0] idx = adr_i[9:2];
  wire hit_ro = (idx == `CG_IDX_COMP_HI) || (idx == `CG_IDX_COMP_LO) || (idx == `CG_IDX_ENER_HI)
    || (idx == `CG_IDX_ENER_LO) || (idx == `CG_IDX_NOM_LO) || (idx == `CG_IDX_CPI) || (idx == `CG_IDX_FLAGS);
  wire hit_rw = (idx == `CG_IDX_RESET) || (idx == `CG_IDX_NOM_HI) || (idx == `CG_IDX_MFR)
    || (idx == `CG_IDX_VTS) || (idx == `CG_IDX_CTRL);
  wire hit = hit_ro || hit_rw;
  wire wr = req && we_i && sel_i[0] && hit;
  wire [7:0] wb = dat_i[7:0];
  // reset fires on the 00h to 80h transition only
  wire soft_rst = wr && (idx == `CG_IDX_RESET) && (rst_reg_r == `CG_RST_IDLE) && (wb == `CG_RST_TRIGGER);
  wire [4:0] flags = {final_empty_warning, first_empty_warning, vdq_r, brp_r, ci_r};
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      `CG_IDX_COMP_HI: rd_byte = comp_val[15:8];
      `CG_IDX_COMP_LO: rd_byte = comp_val[7:0];
      `CG_IDX_ENER_HI: rd_byte = ener_val[15:8];
      `CG_IDX_ENER_LO: rd_byte = ener_val[7:0];
      `CG_IDX_NOM_HI: rd_byte = nom_r[15:8];
      `CG_IDX_NOM_LO: rd_byte = nom_r[7:0];
      `CG_IDX_MFR: rd_byte = mfr_r[7:0];
      `CG_IDX_CPI: rd_byte = cpi_r;
      `CG_IDX_VTS: rd_byte = vts_r;
      `CG_IDX_FLAGS: rd_byte = {3'h0, flags};
      `CG_IDX_CTRL: rd_byte = {7'h00, sd_dis_r};
      default: rd_byte = 8'h00; // reset register is write-only
    endcase
  end
  //////////////////////////////////////////////////////////////////////////////
  // display mode
  wire timed_trig = display_enable_pin_low && !display_enable_pin_high;
  always_comb begin
    dsp_nxt = dsp_r;
    case (dsp_r)
      CG_DSP_OFF: begin
        if (timed_trig) dsp_nxt = CG_DSP_TIMED;
        else if (!display_enable_pin_high && chg_valid) dsp_nxt = CG_DSP_CHARGE;
      end
      CG_DSP_TIMED: begin
        if (display_enable_pin_high) dsp_nxt = CG_DSP_OFF;
        else if (tmr_r == 32'h1) dsp_nxt = CG_DSP_OFF;
      end
      CG_DSP_CHARGE: begin
        if (display_enable_pin_high || !chg_valid) dsp_nxt = CG_DSP_OFF;
        else if (timed_trig) dsp_nxt = CG_DSP_TIMED;
      end
      default: dsp_nxt = CG_DSP_OFF;
    endcase
  end
  wire show = (dsp_r != CG_DSP_OFF) && !display_enable_pin_high;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dh_sync_r <= 2'b00;
      dl_sync_r <= 2'b00;
      vc_sync_r <= 2'b00;
      p5_sync_r <= 2'b00;
    end else begin
      dh_sync_r <= {dh_sync_r[0], display_enable_high_i};
      dl_sync_r <= {dl_sync_r[0], display_enable_low_i};
      vc_sync_r <= {vc_sync_r[0], valid_charge_i};
      p5_sync_r <= {p5_sync_r[0], fifth_program_input_i};
    end
  end
  // bus answer: one cycle after the request, dropped the next cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0;
    end else begin
      ack_r <= req && hit;
      err_r <= req && !hit;
      dat_r <= (req && !we_i) ? {24'h0, rd_byte} : 32'h0;
    end
  end
  // gauge state; hardware reset loads zeros except vts_r (CG_VTS_RESET), the gauge reset loads PROG_FULL and sets ci and brp
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      mfr_r <= 16'h0;
      nom_r <= 16'h0;
      cpi_r <= 8'h00;
      ci_r <= 1'b0;
      brp_r <= 1'b0;
      vdq_r <= 1'b0;
      vts_r <= `CG_VTS_RESET;
      rst_reg_r <= `CG_RST_IDLE;
      sd_dis_r <= 1'b0;
    end else begin
      nom_r <= nominal_charge_count_i;
      sd_dis_r <= p5_sync_r[1];
      if (wr && idx == `CG_IDX_RESET) rst_reg_r <= wb & `CG_RST_TRIGGER;
      if (wr && idx == `CG_IDX_VTS) vts_r <= wb;
      if (wr && idx == `CG_IDX_MFR) mfr_r <= {8'h00, wb};
      if (soft_rst || gauge_reset_o) begin
        mfr_r <= PROG_FULL;
        nom_r <= 16'h0;
        cpi_r <= 8'h00;
        vdq_r <= 1'b0;
        ci_r <= 1'b1;
        brp_r <= 1'b1;
      end
    end
  end
  // first cycle after power-on reset also performs the gauge reset
  logic por_r;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      por_r <= 1'b1;
      gauge_reset_o <= 1'b0;
    end else begin
      por_r <= 1'b0;
      gauge_reset_o <= por_r || soft_rst;
    end
  end
  // display timer and mode register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      dsp_r <= CG_DSP_OFF;
      tmr_r <= 32'h0;
    end else begin
      dsp_r <= dsp_nxt;
      if (dsp_r != CG_DSP_TIMED && dsp_nxt == CG_DSP_TIMED) tmr_r <= DISPLAY_ENABLE_PIN_CYCLES;
      else if (tmr_r != 32'h0) tmr_r <= tmr_r - 32'h1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  cg_led_mux u_mux (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .show_i(show),
    .lit_i(lit),
    .first_empty_warning_i(first_empty_warning),
    .final_empty_warning_i(final_empty_warning),
    .seg_o(segment_outputs_o),
    .com_o(led_common_o)
  );
  assign ack_o = ack_r;
  assign err_o = err_r;
  assign dat_o = dat_r;
  assign self_discharge_en_o = !sd_dis_r;
  assign measured_full_reference_o = mfr_r;
endmodule : cg_gauge_display
`default_nettype wire

// [test/cg_pin_model.sv]
`default_nettype none
module cg_pin_model (
  // wanted pin state: 0 floating, 1 tied high, 2 pulled low
  input wire logic [1:0] mode_i,
  // sense lines toward the device
  output logic high_o,
  output logic low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // floating drives neither line, so the device sees both low
  assign high_o = (mode_i == 2'd1);
  assign low_o = (mode_i == 2'd2);
endmodule : cg_pin_model
`default_nettype wire

// [test/cg_gauge_props.sv]
`default_nettype none
module cg_gauge_props #(
  parameter logic [15:0] PROG_FULL = 16'h1000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bus
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o,
  // pins and status
  input wire logic fifth_program_input_i,
  input wire logic display_enable_high_i,
  input wire logic [4:0] segment_outputs_o,
  input wire logic led_common_o,
  input wire logic gauge_reset_o,
  input wire logic self_discharge_en_o,
  input wire logic [15:0] measured_full_reference_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o && !err_o;
  endsequence
  sequence s_answer;
    ack_o ^ err_o;
  endsequence
  a_req_answer: assert property (s_take |=> s_answer) else $error("no answer");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack stuck");
  a_ack_cause: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i)) else $error("stray ack");
  a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper bits set");
  a_banks_apart: assert property (!((|(segment_outputs_o & 5'h15)) && (|(segment_outputs_o & 5'h0a))))
    else $error("banks overlap");
  a_common_lit: assert property (led_common_o == (|segment_outputs_o)) else $error("common wrong");
  a_pin_dark: assert property (display_enable_high_i [*6] |-> segment_outputs_o == 5'h00)
    else $error("lit with pin high");
  a_reset_full: assert property (gauge_reset_o |-> ##[1:2] measured_full_reference_o == PROG_FULL)
    else $error("full ref not loaded");
  a_strap_off: assert property (fifth_program_input_i [*5] |-> !self_discharge_en_o)
    else $error("self discharge on");
endmodule : cg_gauge_props
bind cg_gauge_display cg_gauge_props #(.PROG_FULL(PROG_FULL)) props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
  .fifth_program_input_i(fifth_program_input_i), .display_enable_high_i(display_enable_high_i),
  .segment_outputs_o(segment_outputs_o), .led_common_o(led_common_o), .gauge_reset_o(gauge_reset_o),
  .self_discharge_en_o(self_discharge_en_o), .measured_full_reference_o(measured_full_reference_o));
`default_nettype wire

// [test/capacity_led_display_and_reset_test.sv]
`default_nettype none
module capacity_led_display_and_reset_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cg_pkg::*;
  logic clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, ack, err, gres, sden, com, vchg = 0, p5 = 0, hi, lo, re;
  logic [9:0] adr = 0;
  logic [31:0] wdat = 0, dat_o, rdat;
  logic [15:0] nom = 16'h1000, mfr;
  logic [7:0] volt = 8'hff, der = 8'hff;
  logic [4:0] seg;
  logic [1:0] pin = 0;
  int fail_count = 0, compares = 0, resets = 0;
  cg_pin_model pins (.mode_i(pin), .high_o(hi), .low_o(lo));
  cg_gauge_display #(.DISPLAY_ENABLE_PIN_CYCLES(2000)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack), .err_o(err),
    .nominal_charge_count_i(nom), .temp_derate_i(der), .cell_voltage_input_i(volt), .valid_charge_i(vchg),
    .fifth_program_input_i(p5), .display_enable_high_i(hi), .display_enable_low_i(lo),
    .segment_outputs_o(seg), .led_common_o(com), .gauge_reset_o(gres), .self_discharge_en_o(sden),
    .measured_full_reference_o(mfr));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (gres) resets <= resets + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // one classic cycle; answer awaited without a bound, then checked to come on the second edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack || err));
    chk("bus answer", n, 2);
    rdat = dat_o;
    re = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
    wb(1'b0, idx, 8'h00);
    chk(name, rdat, {24'h0, exp});
  endtask : rd
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #800000;
    fail_count++;
    end_of_test();
  end
  initial begin
    tick(10);
    rst_n_i <= 1'b1;
    tick(4);
    chk("power-on reset", resets, 1);
    chk("full ref", mfr, 16'h1000);
    rd(8'h3a, 8'h03, "flags");
    rd(8'h09, 8'h00, "cpi");
    $display("test reset done");
    // display work stays early: bank 1/3/5 owns the first 30% of the mux period
    pin <= 2'd2;
    tick(5);
    pin <= 2'd0;
    tick(15);
    chk("full seg", seg, 5'b10101);
    chk("common lit", com, 1'b1);
    nom <= 16'h0900;
    tick(10);
    chk("half seg", seg, 5'b00101);
    tick(1950);
    chk("seg late", seg, 5'b00101);
    tick(40);
    chk("seg timed out", seg, 5'h00);
    pin <= 2'd1;
    vchg <= 1'b1;
    tick(10);
    chk("pin high", seg, 5'h00);
    pin <= 2'd0;
    tick(10);
    chk("charge shown", seg, 5'b00101);
    pin <= 2'd1;
    tick(10);
    chk("pin high lit", seg, 5'h00);
    chk("common dark", com, 1'b0);
    pin <= 2'd0;
    tick(10);
    chk("charge back", seg, 5'b00101);
    volt <= 8'h9c;
    tick(10);
    chk("final blank", seg, 5'h00);
    rd(8'h3a, 8'h1b, "flags final");
    volt <= 8'h9d;
    tick(10);
    rd(8'h3a, 8'h0b, "flags first");
    wb(1'b1, 8'h0c, 8'h50);
    volt <= 8'h9c;
    tick(10);
    rd(8'h3a, 8'h03, "flags moved");
    volt <= 8'hff;
    vchg <= 1'b0;
    $display("test display done");
    p5 <= 1'b1;
    tick(6);
    chk("strap", sden, 1'b0);
    rd(8'h3b, 8'h01, "ctrl");
    p5 <= 1'b0;
    tick(6);
    chk("no strap", sden, 1'b1);
    der <= 8'h80;
    tick(4);
    chk("full ref kept", mfr, 16'h1000);
    rd(8'h0d, 8'h04, "comp high");
    rd(8'h0e, 8'h80, "comp low");
    wb(1'b0, 8'h0f, 8'h00);
    chk("energy high", re, 1'b0);
    wb(1'b0, 8'h10, 8'h00);
    chk("energy low", re, 1'b0);
    $display("test compensation done");
    wb(1'b1, 8'h05, 8'h40);
    chk("full ref written", mfr, 16'h0040);
    wb(1'b1, 8'h39, 8'h80);
    tick(3);
    chk("soft reset", resets, 2);
    chk("full ref reload", mfr, 16'h1000);
    wb(1'b1, 8'h05, 8'h40);
    wb(1'b1, 8'h39, 8'h80);
    tick(3);
    chk("no rearm", resets, 2);
    chk("full ref held", mfr, 16'h0040);
    rd(8'h39, 8'h00, "reset reg");
    wb(1'b1, 8'h39, 8'h00);
    wb(1'b1, 8'h39, 8'h80);
    tick(3);
    chk("rearmed", resets, 3);
    wb(1'b0, 8'h20, 8'h00);
    chk("unmapped", re, 1'b1);
    $display("test soft reset done");
    end_of_test();
  end
endmodule : capacity_led_display_and_reset_test
`default_nettype wire
